// file: rtl/elsb_log_sector.sv
/*
 * Error log sector builder: records the last five errors in a ring and
 * serves the 512-byte log sector, one byte per read, over a plain port.
 * Assumes command, error and read events are synchronous one-cycle pulses
 * and that the host side turns byte reads into sector transfers.
 */
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "elsb_consts.svh"
module elsb_log_sector (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic cmd_evt,
	input wire elsb_pkg::elsb_cmd_snap_t cmd_snap,
	input wire elsb_pkg::elsb_pwr_t pwr_state,
	input wire logic err_evt,
	input wire logic err_dev_attr,
	input wire elsb_pkg::elsb_err_desc_t err_desc,
	input wire logic [15:0] power_on_hours,
	input wire logic [9:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [7:0] rd_data
);

	function automatic logic in_slots(input logic [9:0] a);
		return a >= `ELSB_OFF_ENTRY0 && a < `ELSB_OFF_COUNT_LO;
	endfunction

	function automatic logic [2:0] slot_of(input logic [9:0] a);
		logic [9:0] o;
		o = a - `ELSB_OFF_ENTRY0;
		return 3'(o / `ELSB_ENTRY_BYTES);
	endfunction

	function automatic logic [6:0] off_of(input logic [9:0] a);
		logic [9:0] o;
		o = a - `ELSB_OFF_ENTRY0;
		return 7'(o % `ELSB_ENTRY_BYTES);
	endfunction

	function automatic logic [7:0] byte_sum(input elsb_pkg::elsb_entry_t e);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 90; i++) begin
			s = s + e[8*i +: 8];
		end
		return s;
	endfunction

	elsb_pkg::elsb_entry_t entry_q [5];
	logic [7:0] slot_sum_q [5];
	elsb_pkg::elsb_cmd_snap_t hist_q [4];
	logic [2:0] hist_cnt_q;
	elsb_pkg::elsb_cmd_snap_t cur_q;
	logic cur_valid_q;
	elsb_pkg::elsb_pwr_t cur_state_q;
	logic [2:0] index_q;
	logic [2:0] fill_q;
	logic [15:0] count_q;
	logic [7:0] ctrl_q;
	logic [7:0] rd_data_d;
	elsb_pkg::elsb_entry_t new_entry;
	logic [7:0] new_sum;

	// Newest slot is 1-based; zero means the log is still empty.
	wire logic [2:0] next_index = (index_q == `ELSB_SLOTS) ? 3'h1 :
		index_q + 3'h1;
	wire logic [2:0] wr_slot = next_index - 3'h1;
	wire logic hist_en = ctrl_q[`ELSB_CTRL_HIST_BIT];
	wire logic log_now = ce && err_evt;
	wire logic snap_now = ce && cmd_evt;
	wire logic count_full = count_q == `ELSB_COUNT_MAX;

	elsb_entry_pack u_pack (
		.hist(hist_q),
		.hist_cnt(hist_cnt_q),
		.hist_en(hist_en),
		.cur(cur_q),
		.cur_valid(cur_valid_q),
		.desc(err_desc),
		.state(cur_state_q),
		.hours(power_on_hours),
		.entry(new_entry),
		.sum(new_sum)
	);

	// Checksum keeps a running sum per slot, so no 511-byte adder exists.
	wire logic [7:0] fixed_sum = `ELSB_VERSION + {5'h00, index_q} +
		count_q[7:0] + count_q[15:8];
	wire logic [7:0] body_sum = slot_sum_q[0] + slot_sum_q[1] +
		slot_sum_q[2] + slot_sum_q[3] + slot_sum_q[4];
	wire logic [7:0] chksum = 8'h00 - (fixed_sum + body_sum);

	wire logic [2:0] rd_slot = slot_of(addr);
	wire logic [6:0] rd_off = off_of(addr);
	wire logic [7:0] slot_byte = entry_q[rd_slot][{rd_off, 3'b000} +: 8];
	wire logic [7:0] stat_byte = {1'b0, hist_cnt_q, 1'b0, fill_q};

	always_comb begin
		rd_data_d = 8'h00; // Reserved and unmapped bytes read zero.
		if (addr == `ELSB_OFF_VERSION) begin
			rd_data_d = `ELSB_VERSION;
		end else if (addr == `ELSB_OFF_INDEX) begin
			rd_data_d = {5'h00, index_q};
		end else if (in_slots(addr)) begin
			rd_data_d = slot_byte;
		end else if (addr == `ELSB_OFF_COUNT_LO) begin
			rd_data_d = count_q[7:0];
		end else if (addr == `ELSB_OFF_COUNT_HI) begin
			rd_data_d = count_q[15:8];
		end else if (addr == `ELSB_OFF_CHKSUM) begin
			rd_data_d = chksum;
		end else if (addr == `ELSB_OFF_CTRL) begin
			rd_data_d = ctrl_q;
		end else if (addr == `ELSB_OFF_STAT) begin
			rd_data_d = stat_byte;
		end
	end

	always_ff @(posedge mclk) begin
		if (ce && sys_rst) begin
			rd_data <= 8'h00;
		end else if (ce) begin
			rd_data <= rd_strobe ? rd_data_d : 8'h00;
		end
	end

	// Sector bytes are never writable; only the control byte takes writes.
	always_ff @(posedge mclk) begin
		if (ce && sys_rst) begin
			ctrl_q <= `ELSB_CTRL_RST;
		end else if (ce && wr_strobe && addr == `ELSB_OFF_CTRL) begin
			ctrl_q <= wr_data;
		end
	end

	// Command capture: the new command becomes current, the old one history.
	always_ff @(posedge mclk) begin
		if (ce && sys_rst) begin
			cur_q <= '0;
			cur_valid_q <= 1'b0;
			cur_state_q <= `ELSB_PWR_UNKNOWN;
			hist_cnt_q <= 3'h0;
			for (int k = 0; k < 4; k++) begin
				hist_q[k] <= '0;
			end
		end else if (snap_now) begin
			cur_q <= cmd_snap;
			cur_valid_q <= 1'b1;
			cur_state_q <= pwr_state;
			if (cur_valid_q) begin
				for (int k = 0; k < 3; k++) begin
					hist_q[k] <= hist_q[k + 1];
				end
				hist_q[3] <= cur_q;
				if (hist_cnt_q != `ELSB_HIST) begin
					hist_cnt_q <= hist_cnt_q + 3'h1;
				end
			end
		end
	end

	// Ring store; unused slots stay at their reset value of zero.
	always_ff @(posedge mclk) begin
		if (ce && sys_rst) begin
			index_q <= 3'h0;
			fill_q <= 3'h0;
			for (int s = 0; s < 5; s++) begin
				entry_q[s] <= '0;
				slot_sum_q[s] <= 8'h00;
			end
		end else if (log_now) begin
			entry_q[wr_slot] <= new_entry;
			slot_sum_q[wr_slot] <= new_sum;
			index_q <= next_index;
			if (fill_q != `ELSB_SLOTS) begin
				fill_q <= fill_q + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (ce && sys_rst) begin
			count_q <= 16'h0000;
		end else if (log_now && err_dev_attr && !count_full) begin
			count_q <= count_q + 16'h0001;
		end
	end

	version_byte_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ce && rd_strobe && addr == `ELSB_OFF_VERSION |=> rd_data == 8'h01)
		else $error("version byte is not 01h");

	reserved_zero_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ce && rd_strobe && addr >= `ELSB_OFF_RSVD_LO &&
		addr < `ELSB_OFF_CHKSUM |=> rd_data == 8'h00)
		else $error("reserved byte reads nonzero");

	ring_advance_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		log_now |=> index_q == (($past(index_q) == 3'h5) ? 3'h1 :
			$past(index_q) + 3'h1))
		else $error("ring index did not advance by one");

	index_range_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		index_q <= 3'h5 && (fill_q == 3'h0) == (index_q == 3'h0))
		else $error("index out of range or disagrees with fill");

	empty_slot_zero_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ce && rd_strobe && in_slots(addr) && slot_of(addr) >= fill_q &&
		!log_now |=> rd_data == 8'h00)
		else $error("unused slot byte reads nonzero");

	history_zero_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		log_now && (hist_cnt_q == 3'h0 || !hist_en) |=>
		entry_q[$past(wr_slot)][383:0] == '0)
		else $error("history snapshots not zero filled");

	state_sample_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		snap_now ##1 !cmd_evt ##1 (ce && !cmd_evt && err_evt) |=>
		entry_q[$past(wr_slot)][699:696] == $past(pwr_state, 3))
		else $error("state not taken from command time");

	count_step_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		log_now && !err_dev_attr |=> count_q == $past(count_q))
		else $error("count moved for a non-device error");

	count_sat_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		count_full |=> count_full [*2])
		else $error("error count left its maximum");

	no_write_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ce && wr_strobe && !err_evt && addr <= `ELSB_OFF_CHKSUM |=>
		$stable(index_q) && $stable(count_q) && $stable(slot_sum_q[0]))
		else $error("host write altered the log");

	count_low_first_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ce && rd_strobe && addr == `ELSB_OFF_COUNT_LO && !log_now |=>
		rd_data == $past(count_q[7:0]))
		else $error("count low byte not at 452");

	count_high_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ce && rd_strobe && addr == `ELSB_OFF_COUNT_HI && !log_now |=>
		rd_data == $past(count_q[15:8]))
		else $error("count high byte not at 453");

	ce_freeze_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		!ce |=> $stable(rd_data) && $stable(index_q) &&
		$stable(count_q) && $stable(ctrl_q) && $stable(cur_q))
		else $error("state moved while the clock enable was low");

	read_idle_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ce && !rd_strobe |=> rd_data == 8'h00)
		else $error("read data stood beyond its cycle");

	index_read_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ce && rd_strobe && addr == `ELSB_OFF_INDEX && !log_now |=>
		rd_data == {5'h00, $past(index_q)})
		else $error("index byte disagrees with newest slot");

	fill_count_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		log_now && fill_q != 3'h5 |=> fill_q == $past(fill_q) + 3'h1)
		else $error("filled slot count did not grow");

	failing_cmd_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		log_now |=> entry_q[$past(wr_slot)][479:384] == $past(cur_q))
		else $error("fifth snapshot is not the failing command");

	no_cmd_zero_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		log_now && !cur_valid_q |=> entry_q[$past(wr_slot)][479:0] == '0)
		else $error("snapshots not zero with no command seen");

	hist_depth_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		hist_cnt_q <= 3'h4 && (cur_valid_q || hist_cnt_q == 3'h0))
		else $error("history depth out of range");

	cmd_capture_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		snap_now |=> cur_q == $past(cmd_snap) && cur_valid_q)
		else $error("command snapshot not captured");

	entry_desc_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		log_now |=> entry_q[$past(wr_slot)][695:480] == $past(err_desc))
		else $error("error description not stored");

	state_nibble_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		log_now |=> entry_q[$past(wr_slot)][703:700] == 4'h0)
		else $error("state byte high nibble not zero");

	entry_hours_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		log_now |=> entry_q[$past(wr_slot)][719:704] ==
		$past(power_on_hours))
		else $error("power-on hours not stored");

	// Running sums must match the stored bytes, or the checksum drifts.
	for (genvar s = 0; s < 5; s++) begin : g_sum_chk
		slot_sum_a: assert property (
			@(posedge mclk) disable iff (sys_rst)
			slot_sum_q[s] == byte_sum(entry_q[s]))
			else $error("slot sum disagrees with slot bytes");
	end

endmodule // elsb_log_sector
`default_nettype wire

// file: pkg/elsb_consts.svh
/*
 * Offsets, field positions, reset values and fixed sizes of the error
 * log sector builder.
 * Assumes it is included by bare name wherever a design file needs it.
 */
`ifndef ELSB_CONSTS_SVH
`define ELSB_CONSTS_SVH

`define ELSB_VERSION 8'h01
`define ELSB_OFF_VERSION 10'h000
`define ELSB_OFF_INDEX 10'h001
`define ELSB_OFF_ENTRY0 10'h002
`define ELSB_ENTRY_BYTES 10'h05A
`define ELSB_OFF_COUNT_LO 10'h1C4
`define ELSB_OFF_COUNT_HI 10'h1C5
`define ELSB_OFF_RSVD_LO 10'h1C6
`define ELSB_OFF_CHKSUM 10'h1FF
`define ELSB_OFF_CTRL 10'h200
`define ELSB_OFF_STAT 10'h201
`define ELSB_SLOTS 3'h5
`define ELSB_HIST 3'h4
`define ELSB_COUNT_MAX 16'hFFFF
`define ELSB_CTRL_HIST_BIT 0
`define ELSB_CTRL_RST 8'h01
`define ELSB_STAT_FILL_LSB 0
`define ELSB_STAT_HIST_LSB 4
`define ELSB_PWR_UNKNOWN 4'h0
`define ELSB_PWR_SLEEP 4'h1
`define ELSB_PWR_STANDBY 4'h2
`define ELSB_PWR_ACTIVE 4'h3
`define ELSB_PWR_OFFLINE 4'h4

`endif

// file: pkg/elsb_pkg.sv
/*
 * Types shared by the error log sector builder files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package elsb_pkg;

	typedef logic [3:0] elsb_pwr_t;

	typedef struct packed {
		logic [31:0] stamp;
		logic [7:0] command;
		logic [7:0] dev_head;
		logic [7:0] cyl_hi;
		logic [7:0] cyl_lo;
		logic [7:0] sec_num;
		logic [7:0] sec_cnt;
		logic [7:0] features;
		logic [7:0] dev_ctl;
	} elsb_cmd_snap_t;

	typedef struct packed {
		logic [151:0] ext_info;
		logic [7:0] status;
		logic [7:0] dev_head;
		logic [7:0] cyl_hi;
		logic [7:0] cyl_lo;
		logic [7:0] sec_num;
		logic [7:0] sec_cnt;
		logic [7:0] error;
		logic [7:0] dev_ctl;
	} elsb_err_desc_t;

	typedef logic [719:0] elsb_entry_t;

endpackage
`default_nettype wire

// file: rtl/elsb_entry_pack.sv
/*
 * Packs one 90-byte error entry, byte 0 in the low bits, and its byte sum.
 * Assumes all inputs are stable while the caller stores the result.
 */
`timescale 1ns/1ns
`default_nettype none
module elsb_entry_pack (
	input wire elsb_pkg::elsb_cmd_snap_t hist [4],
	input wire logic [2:0] hist_cnt,
	input wire logic hist_en,
	input wire elsb_pkg::elsb_cmd_snap_t cur,
	input wire logic cur_valid,
	input wire elsb_pkg::elsb_err_desc_t desc,
	input wire elsb_pkg::elsb_pwr_t state,
	input wire logic [15:0] hours,
	output elsb_pkg::elsb_entry_t entry,
	output logic [7:0] sum
);
	wire logic [95:0] snap_zero = '0;
	logic [7:0] acc;

	// Oldest of four preceding commands sits in the first snapshot.
	generate
		for (genvar k = 0; k < 4; k++) begin : g_hist
			wire logic keep = hist_en && ({1'b0, hist_cnt} >= 4'(4 - k));
			assign entry[96*k +: 96] = keep ? hist[k] : snap_zero;
		end
	endgenerate

	assign entry[479:384] = cur_valid ? cur : snap_zero;
	assign entry[719:480] = {hours, 4'h0, state, desc};

	always_comb begin
		acc = 8'h00;
		for (int i = 0; i < 90; i++) begin
			acc = acc + entry[8*i +: 8];
		end
		sum = acc;
	end
endmodule // elsb_entry_pack
`default_nettype wire

// file: tb/elsb_host_model.sv
/*
 * Host-side model that reads the error log sector byte by byte.
 * Assumes the register port answers one cycle after a read strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module elsb_host_model (
	input wire logic mclk,
	output logic [9:0] addr,
	output logic [7:0] wr_data,
	output logic wr_strobe,
	output logic rd_strobe,
	input wire logic [7:0] rd_data
);
	logic [7:0] sec [512];
	initial begin
		addr = 10'h3ff;
		wr_data = 8'h00;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
	end
	// Released lines show the inverse so a stale value cannot pass.
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_strobe <= 1'b1;
		@(posedge mclk);
		wr_strobe <= 1'b0;
		addr <= ~a;
		wr_data <= ~d;
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge mclk);
		rd_strobe <= 1'b0;
		addr <= ~a;
		@(negedge mclk);
		d = rd_data;
	endtask
	// Reads run back to back; the log itself is never written.
	task automatic read_sector();
		for (int j = 0; j <= 512; j++) begin
			@(posedge mclk);
			addr <= j[9:0];
			rd_strobe <= (j < 512);
			@(negedge mclk);
			if (j > 0) begin
				sec[j - 1] = rd_data;
			end
		end
	endtask
endmodule // elsb_host_model
`default_nettype wire

// file: tb/tb_elsb_log_sector.sv
/*
 * Self-checking bench for the error log sector builder.
 * Assumes the host model owns the register port.
 */
`timescale 1ns/1ns
`default_nettype none
`include "elsb_consts.svh"
module tb_elsb_log_sector;
	logic mclk = 1'b0;
	logic sys_rst, cmd_evt, err_evt, err_dev_attr, wr_strobe, rd_strobe;
	logic ce;
	elsb_pkg::elsb_cmd_snap_t cmd_snap;
	elsb_pkg::elsb_pwr_t pwr_state, cur_pwr;
	elsb_pkg::elsb_err_desc_t err_desc;
	logic [15:0] power_on_hours, cnt;
	logic [9:0] addr;
	logic [7:0] wr_data, rd_data, b;
	logic [7:0] exp_b [512];
	logic [719:0] ent [5];
	logic [95:0] cq [$];
	logic hist_en;
	int err_total, cmp_count, nerr, n;

	always #50 mclk = ~mclk;

	elsb_log_sector elsb_log_sector_i (.mclk(mclk), .sys_rst(sys_rst),
		.ce(ce), .cmd_evt(cmd_evt), .cmd_snap(cmd_snap),
		.pwr_state(pwr_state), .err_evt(err_evt), .err_dev_attr(err_dev_attr),
		.err_desc(err_desc), .power_on_hours(power_on_hours), .addr(addr),
		.wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
		.rd_data(rd_data));
	elsb_host_model elsb_host_model_i (.mclk(mclk), .addr(addr),
		.wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
		.rd_data(rd_data));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic void build_exp();
		logic [7:0] s;
		s = 8'h00;
		exp_b[0] = `ELSB_VERSION;
		exp_b[1] = (nerr == 0) ? 8'h00 : 8'((nerr - 1) % 5 + 1);
		for (int i = 0; i < 450; i++) begin
			exp_b[2 + i] = ent[i / 90][8 * (i % 90) +: 8];
		end
		exp_b[452] = cnt[7:0];
		exp_b[453] = cnt[15:8];
		for (int i = 454; i < 511; i++) begin
			exp_b[i] = 8'h00;
		end
		for (int i = 0; i < 511; i++) begin
			s = s + exp_b[i];
		end
		exp_b[511] = -s;
	endfunction

	task automatic check_sector(input string name);
		int base;
		elsb_host_model_i.read_sector();
		build_exp();
		for (int i = 0; i < 512; i++) begin
			chk(elsb_host_model_i.sec[i], exp_b[i]);
		end
		chk(elsb_host_model_i.sec[0], 8'h01);
		chk(elsb_host_model_i.sec[1], exp_b[1]);
		chk(elsb_host_model_i.sec[452], cnt[7:0]);
		chk(elsb_host_model_i.sec[511], exp_b[511]);
		base = 2 + 90 * ((nerr + 4) % 5);
		for (int k = 0; k < 90 && nerr > 0; k++) begin
			if (k < 60) begin
				chk(elsb_host_model_i.sec[base + k], exp_b[base + k]);
			end else begin
				chk(elsb_host_model_i.sec[base + k], exp_b[base + k]);
			end
		end
		$display("test %s done", name);
	endtask

	task automatic do_cmd(input logic [3:0] p);
		logic [95:0] v;
		v = {$urandom, $urandom, $urandom};
		@(posedge mclk);
		cmd_snap <= v;
		pwr_state <= p;
		cmd_evt <= 1'b1;
		@(posedge mclk);
		cmd_evt <= 1'b0;
		pwr_state <= ~p;
		cq.push_back(v);
		cur_pwr = p;
	endtask

	task automatic do_err();
		logic [239:0] d;
		logic [719:0] e;
		logic [15:0] h;
		logic a;
		for (int i = 0; i < 8; i++) begin
			d = {d[207:0], $urandom};
		end
		h = 16'($urandom);
		a = 1'($urandom);
		@(posedge mclk);
		err_desc <= d[215:0];
		power_on_hours <= h;
		err_dev_attr <= a;
		err_evt <= 1'b1;
		@(posedge mclk);
		err_evt <= 1'b0;
		power_on_hours <= ~h;
		e = '0;
		for (int k = 0; k < 4; k++) begin
			if (hist_en && cq.size() - 5 + k >= 0) begin
				e[96 * k +: 96] = cq[cq.size() - 5 + k];
			end
		end
		e[384 +: 96] = (cq.size() > 0) ? cq[$] : '0;
		e[480 +: 216] = d[215:0];
		e[696 +: 8] = {4'h0, cur_pwr};
		e[704 +: 16] = h;
		ent[nerr % 5] = e;
		nerr++;
		if (a && cnt != 16'hffff) begin
			cnt++;
		end
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		final_report();
	end

	initial begin
		{sys_rst, cmd_evt, err_evt, err_dev_attr} = 4'h8;
		cmd_snap = '0;
		pwr_state = 4'h0;
		err_desc = '0;
		power_on_hours = 16'h0000;
		ce = 1'b1;
		nerr = 0;
		cnt = 16'h0000;
		cur_pwr = `ELSB_PWR_UNKNOWN;
		hist_en = 1'b1;
		for (int s = 0; s < 5; s++) begin
			ent[s] = '0;
		end
		void'($urandom(32'h2106));
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		check_sector("empty");
		elsb_host_model_i.rd(`ELSB_OFF_CTRL, b);
		chk(b, `ELSB_CTRL_RST);
		elsb_host_model_i.rd(10'h3ff, b);
		chk(b, 8'h00);
		elsb_host_model_i.wr(10'h000, 8'h5a);
		elsb_host_model_i.wr(10'h1c4, 8'h5a);
		check_sector("write refused");
		chk(elsb_host_model_i.sec[452], 8'h00);
		for (int e = 0; e < 8; e++) begin
			n = (e < 2) ? e + 1 : $urandom_range(1, 6);
			// History is switched off once so the zero fill shows.
			hist_en = (e != 6);
			elsb_host_model_i.wr(`ELSB_OFF_CTRL, {7'h00, hist_en});
			for (int c = 0; c < n; c++) begin
				do_cmd(e < 5 ? 4'(e) : 4'($urandom));
			end
			do_err();
			check_sector("error");
		end
		// Events and a write while the clock enable is low must be lost.
		@(posedge mclk);
		ce <= 1'b0;
		cmd_evt <= 1'b1;
		err_evt <= 1'b1;
		elsb_host_model_i.wr(`ELSB_OFF_CTRL, 8'h00);
		{ce, cmd_evt, err_evt} <= 3'b100;
		check_sector("clock enable");
		elsb_host_model_i.rd(`ELSB_OFF_CTRL, b);
		chk(b, {7'h00, hist_en});
		// A second reset empties the log; the next error has no commands.
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		cq.delete();
		nerr = 0;
		cnt = 16'h0000;
		hist_en = 1'b1;
		cur_pwr = `ELSB_PWR_UNKNOWN;
		for (int s = 0; s < 5; s++) begin
			ent[s] = '0;
		end
		do_err();
		check_sector("reset");
		final_report();
	end
endmodule // tb_elsb_log_sector
`default_nettype wire
